// [pkg/crcsn_pkg.sv]
// package: register map, field layout, timing and carrier types of the crc snoop block
package crcsn_pkg;

  // register bus
  localparam int          AXI_ADDR_W       = 8;
  localparam logic [7:0]  OFF_CTRL         = 8'h00;
  localparam logic [7:0]  OFF_INPUT        = 8'h04;
  localparam logic [7:0]  OFF_RESULT       = 8'h08;
  localparam logic [7:0]  OFF_SNOOP        = 8'h0C;
  localparam logic [7:0]  OFF_STATUS       = 8'h10;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // field positions
  localparam int          CTRL_POLY_BIT    = 0;
  localparam int          SAR_WR_BIT       = 15;
  localparam int          SAR_RD_BIT       = 14;
  localparam int          SAR_ADDR_W       = 14;
  localparam int          STATUS_BUSY_BIT  = 0;
  localparam int          STATUS_OVF_BIT   = 1;

  // reset values
  localparam logic        RST_POLY         = 1'b0;
  localparam logic [15:0] RST_SAR          = 16'h0000;
  localparam logic [15:0] RST_CRC          = 16'h0000;
  localparam logic [7:0]  RST_INPUT        = 8'h00;

  // generator polynomials, msb-first form without the x^16 term
  localparam logic [15:0] POLY_CCITT       = 16'h1021;
  localparam logic [15:0] POLY_CRC16       = 16'h8005;

  // lowest peripheral address that may be snooped is strictly above this
  localparam logic [15:0] SNOOP_FLOOR      = 16'h0020;

  // clock 100 MHz; a byte is folded within two cycles of its capture, three if a preset or a coinciding snooped byte holds it back
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          UPDATE_CYCLES    = 2;
  localparam int          BUF_DEPTH        = 2;

  typedef enum logic [2:0] {
    SEL_CTRL   = 3'b000,
    SEL_INPUT  = 3'b001,
    SEL_RESULT = 3'b010,
    SEL_SNOOP  = 3'b011,
    SEL_STATUS = 3'b100,
    SEL_NONE   = 3'b111
  } crcsn_sel_e;

  // one transfer seen on the peripheral register bus
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] data;
  } crcsn_snoop_s;

  // a byte travelling towards the crc engine
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } crcsn_byte_s;

endpackage

// [rtl/crcsn_byte_fifo.sv]
// two-entry byte buffer between the capture logic and the crc engine
`timescale 1ns/1ps
module crcsn_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock, reset, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [PTR_W:0]              count;
  } crcsn_fifo_s;

  crcsn_fifo_s r_q;
  crcsn_fifo_s r_d;
  logic        push;
  logic        pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1)) begin
      return '0;
    end
    return p + PTR_W'(1);
  endfunction

  assign in_ready  = (r_q.count != (PTR_W + 1)'(DEPTH));
  assign out_valid = (r_q.count != '0);
  assign out_data  = r_q.mem[r_q.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    r_d = r_q;
    if (push) begin
      r_d.mem[r_q.wr_ptr] = in_data;
      r_d.wr_ptr          = bump(r_q.wr_ptr);
    end
    if (pop) begin
      r_d.rd_ptr = bump(r_q.rd_ptr);
    end
    if (push && !pop) begin
      r_d.count = r_q.count + (PTR_W + 1)'(1);
    end else if (pop && !push) begin
      r_d.count = r_q.count - (PTR_W + 1)'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

endmodule // crcsn_byte_fifo

// [rtl/crcsn_crc_engine.sv]
// byte-serial crc-16 engine with two selectable polynomials
`timescale 1ns/1ps
module crcsn_crc_engine (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // configuration
  input  wire logic        poly_sel,
  // preset of the running code
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  // byte stream
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_byte,
  output logic             in_ready,
  // running code
  output logic [15:0]      crc
);

  typedef struct packed {
    logic [15:0] crc;
  } crcsn_eng_s;

  crcsn_eng_s r_q;
  crcsn_eng_s r_d;

  // fold one byte, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [7:0] b, input logic sel);
    logic [15:0] c;
    logic [15:0] poly;
    logic        fb;
    c    = c_in;
    poly = sel ? crcsn_pkg::POLY_CRC16 : crcsn_pkg::POLY_CCITT; // RULE1
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c  = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ poly;
      end
    end
    return c;
  endfunction

  // a preset from software takes the cycle, so the stream waits
  assign in_ready = !load;
  assign crc      = r_q.crc;

  always_comb begin
    r_d = r_q;
    if (load) begin
      r_d.crc = load_value;
    end else if (in_valid) begin
      r_d.crc = crc_step(r_q.crc, in_byte, poly_sel); // RULE2 RULE3 RULE5
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q.crc <= crcsn_pkg::RST_CRC;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

endmodule // crcsn_crc_engine

// [rtl/crcsn_top.sv]
// crc calculator with peripheral bus snoop behind an axi4-lite register slave
//
// Behaviour
// RULE1 - code uses either the CCITT or the CRC-16 generator polynomial, as selected.
// RULE2 - the code is 16 bits and covers a block of whole bytes.
// RULE3 - every byte delivered to the input register is folded and the result updated.
// RULE4 - software presets the result register before feeding the first byte of a block.
// RULE5 - each byte's update completes within two clock cycles after the byte arrives; here a byte held back by a coinciding snooped byte or a preset takes three.
// RULE6 - only peripheral addresses above 0x0020 can be snooped; lower ones never are.
// RULE7 - snoop address register holds target; its two top bits enable read, write snoop.
// RULE8 - a snooped write to the target captures the byte and updates the result.
// RULE9 - a snooped read of the target captures the returned byte and updates the result.
// RULE10 - one byte per update; a word access contributes only its low byte.
// RULE11 - snooping is passive and adds no cycles to the peripheral bus.
// RULE12 - one configuration bit picks the polynomial: zero CCITT, one CRC-16.
// RULE13 - a software byte coinciding with a snooped byte is kept; both fold in order.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module crcsn_top (
  // clock, reset, enable
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic                                ce,
  // axi4-lite write address
  input  wire logic [crcsn_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // axi4-lite read address
  input  wire logic [crcsn_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // peripheral register bus, observed only
  input  wire crcsn_pkg::crcsn_snoop_s             snoop_bus
);

  typedef struct packed {
    logic                                 aw_have;
    logic [crcsn_pkg::AXI_ADDR_W-1:0]     aw_addr;
    logic                                 w_have;
    logic [31:0]                          w_data;
    logic [3:0]                           w_strb;
    logic                                 bvalid;
    logic [1:0]                           bresp;
    logic                                 rvalid;
    logic [1:0]                           rresp;
    logic [31:0]                          rdata;
    logic                                 poly_q;
    logic [15:0]                          sar_q;
    logic [7:0]                           in_byte_q;
    logic                                 pend_v;
    logic [7:0]                           pend_b;
    logic                                 ovf_q;
  } crcsn_regs_s;

  crcsn_regs_s           r_q;
  crcsn_regs_s           r_d;
  crcsn_pkg::crcsn_sel_e wr_sel;
  crcsn_pkg::crcsn_sel_e rd_sel;
  crcsn_pkg::crcsn_byte_s snoop_byte;
  crcsn_pkg::crcsn_byte_s push_byte;
  logic                  wr_go;
  logic                  aw_take;
  logic                  w_take;
  logic                  ar_take;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [7:0]            fifo_out_data;
  logic                  eng_ready;
  logic                  eng_load;
  logic [15:0]           eng_load_value;
  logic [15:0]           crc_value;
  logic                  addr_ok;
  logic                  dir_ok;

  // word address decode, low two bits ignored
  function automatic crcsn_pkg::crcsn_sel_e decode(input logic [crcsn_pkg::AXI_ADDR_W-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == crcsn_pkg::OFF_CTRL) begin
      return crcsn_pkg::SEL_CTRL;
    end else if (w == crcsn_pkg::OFF_INPUT) begin
      return crcsn_pkg::SEL_INPUT;
    end else if (w == crcsn_pkg::OFF_RESULT) begin
      return crcsn_pkg::SEL_RESULT;
    end else if (w == crcsn_pkg::OFF_SNOOP) begin
      return crcsn_pkg::SEL_SNOOP;
    end else if (w == crcsn_pkg::OFF_STATUS) begin
      return crcsn_pkg::SEL_STATUS;
    end
    return crcsn_pkg::SEL_NONE;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      m[15:8] = nw[15:8];
    end
    return m;
  endfunction

  assign wr_sel = decode(r_q.aw_addr);
  assign rd_sel = decode(s_axi_araddr);

  // handshakes are frozen while the clock enable is low
  assign s_axi_awready = ce && !r_q.aw_have;
  assign s_axi_wready  = ce && !r_q.w_have;
  assign s_axi_arready = ce && !r_q.rvalid;
  assign s_axi_bvalid  = r_q.bvalid;
  assign s_axi_bresp   = r_q.bresp;
  assign s_axi_rvalid  = r_q.rvalid;
  assign s_axi_rresp   = r_q.rresp;
  assign s_axi_rdata   = r_q.rdata;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // a write to the input register waits while a software byte is still pending
  assign wr_go = r_q.aw_have && r_q.w_have && !r_q.bvalid
              && !((wr_sel == crcsn_pkg::SEL_INPUT) && r_q.pend_v);

  assign eng_load       = wr_go && (wr_sel == crcsn_pkg::SEL_RESULT); // RULE4
  assign eng_load_value = merge16(crc_value, r_q.w_data[15:0], r_q.w_strb[1:0]);

  // passive snoop match: no signal goes back to the peripheral bus
  assign addr_ok = (snoop_bus.addr > crcsn_pkg::SNOOP_FLOOR) // RULE6
                && (snoop_bus.addr == {{(16 - crcsn_pkg::SAR_ADDR_W){1'b0}},
                                       r_q.sar_q[crcsn_pkg::SAR_ADDR_W-1:0]}); // RULE7
  assign dir_ok  = snoop_bus.write ? r_q.sar_q[crcsn_pkg::SAR_WR_BIT]  // RULE8
                                   : r_q.sar_q[crcsn_pkg::SAR_RD_BIT]; // RULE9
  assign snoop_byte.valid = snoop_bus.valid && addr_ok && dir_ok; // RULE11
  assign snoop_byte.data  = snoop_bus.data[7:0]; // RULE10

  // snooped byte goes first; the pending software byte follows when the slot is free
  always_comb begin
    if (snoop_byte.valid) begin
      push_byte = snoop_byte;
    end else begin
      push_byte.valid = r_q.pend_v; // RULE13
      push_byte.data  = r_q.pend_b;
    end
  end

  always_comb begin
    r_d = r_q;

    if (aw_take) begin
      r_d.aw_have = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      r_d.w_have = 1'b1;
      r_d.w_data = s_axi_wdata;
      r_d.w_strb = s_axi_wstrb;
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end

    // software byte leaves the pending slot when it reaches the buffer
    if (!snoop_byte.valid && r_q.pend_v && fifo_in_ready) begin
      r_d.pend_v = 1'b0; // RULE13
    end
    if (push_byte.valid && fifo_in_ready) begin
      r_d.in_byte_q = push_byte.data; // RULE3
    end
    // a snooped byte that finds the buffer full is flagged, not lost silently
    if (snoop_byte.valid && !fifo_in_ready) begin
      r_d.ovf_q = 1'b1;
    end

    if (wr_go) begin
      r_d.aw_have = 1'b0;
      r_d.w_have  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = crcsn_pkg::RESP_OKAY;
      case (wr_sel)
        crcsn_pkg::SEL_CTRL: begin
          if (r_q.w_strb[0]) begin
            r_d.poly_q = r_q.w_data[crcsn_pkg::CTRL_POLY_BIT]; // RULE12
          end
        end
        crcsn_pkg::SEL_INPUT: begin
          if (r_q.w_strb[0]) begin
            r_d.pend_v = 1'b1; // RULE13
            r_d.pend_b = r_q.w_data[7:0];
          end
        end
        crcsn_pkg::SEL_RESULT: begin
          r_d.bresp = crcsn_pkg::RESP_OKAY;
        end
        crcsn_pkg::SEL_SNOOP: begin
          r_d.sar_q = merge16(r_q.sar_q, r_q.w_data[15:0], r_q.w_strb[1:0]); // RULE7
        end
        crcsn_pkg::SEL_STATUS: begin
          // write one clears; a fresh overflow in the same cycle wins
          if (r_q.w_strb[0] && r_q.w_data[crcsn_pkg::STATUS_OVF_BIT]
              && !(snoop_byte.valid && !fifo_in_ready)) begin
            r_d.ovf_q = 1'b0;
          end
        end
        default: begin
          r_d.bresp = crcsn_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = crcsn_pkg::RESP_OKAY;
      r_d.rdata  = '0;
      case (rd_sel)
        crcsn_pkg::SEL_CTRL: begin
          r_d.rdata[crcsn_pkg::CTRL_POLY_BIT] = r_q.poly_q;
        end
        crcsn_pkg::SEL_INPUT: begin
          r_d.rdata[7:0] = r_q.in_byte_q;
        end
        crcsn_pkg::SEL_RESULT: begin
          r_d.rdata[15:0] = crc_value;
        end
        crcsn_pkg::SEL_SNOOP: begin
          r_d.rdata[15:0] = r_q.sar_q;
        end
        crcsn_pkg::SEL_STATUS: begin
          r_d.rdata[crcsn_pkg::STATUS_BUSY_BIT] = r_q.pend_v || fifo_out_valid;
          r_d.rdata[crcsn_pkg::STATUS_OVF_BIT]  = r_q.ovf_q;
        end
        default: begin
          r_d.rresp = crcsn_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q           <= '0;
      r_q.poly_q    <= crcsn_pkg::RST_POLY;
      r_q.sar_q     <= crcsn_pkg::RST_SAR;
      r_q.in_byte_q <= crcsn_pkg::RST_INPUT;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  crcsn_byte_fifo #(
    .WIDTH (8),
    .DEPTH (crcsn_pkg::BUF_DEPTH)
  ) u_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (push_byte.valid),
    .in_data   (push_byte.data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (eng_ready)
  );

  crcsn_crc_engine u_eng (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .poly_sel   (r_q.poly_q),
    .load       (eng_load),
    .load_value (eng_load_value),
    .in_valid   (fifo_out_valid),
    .in_byte    (fifo_out_data),
    .in_ready   (eng_ready),
    .crc        (crc_value)
  );

endmodule // crcsn_top

// [sim/crcsn_chk.sv]
// register bus assertions for the crc snoop block
`timescale 1ns/1ps
module crcsn_chk (
  // clock, reset, enable
  input wire logic                             aclk,
  input wire logic                             aresetn,
  input wire logic                             ce,
  // write side
  input wire logic [crcsn_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                             s_axi_awvalid,
  input wire logic                             s_axi_awready,
  input wire logic                             s_axi_wvalid,
  input wire logic                             s_axi_wready,
  input wire logic [1:0]                       s_axi_bresp,
  input wire logic                             s_axi_bvalid,
  input wire logic                             s_axi_bready,
  // read side
  input wire logic [crcsn_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                             s_axi_arvalid,
  input wire logic                             s_axi_arready,
  input wire logic [31:0]                      s_axi_rdata,
  input wire logic [1:0]                       s_axi_rresp,
  input wire logic                             s_axi_rvalid,
  input wire logic                             s_axi_rready,
  // peripheral bus
  input wire crcsn_pkg::crcsn_snoop_s          snoop_bus
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wt, art;
  assign wt  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign art = s_axi_arvalid && s_axi_arready;

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
    else $error("read data dropped early");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_lat_a: assert property (art |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  ce_stall_a: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready while clock enable low");
  wr_resp_a: assert property (wt |-> ##[1:6] s_axi_bvalid)
    else $error("write answer missing");
  wr_err_a: assert property (wt && s_axi_awaddr[7:2] > 6'h4 |-> ##[1:6] s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  rd_err_a: assert property (art && s_axi_araddr[7:2] > 6'h4 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  ctrl_rd_a: assert property (art && s_axi_araddr == 8'h00 |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:1] == 31'h0)
    else $error("control read malformed");

  cover property (wt);
  cover property (art && s_axi_araddr[7:2] > 6'h4);
  cover property (snoop_bus.valid && snoop_bus.write);
  cover property (!ce);
endmodule  // crcsn_chk

bind crcsn_top crcsn_chk crcsn_chk_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .snoop_bus);

// [sim/crcsn_periph_model.sv]
// peripheral bus model: one-cycle cpu or dma accesses seen by the snoop port
`timescale 1ns/1ps
module crcsn_periph_model (
  // clock
  input wire logic                aclk,
  // access request
  input wire logic                go,
  input wire logic                wr,
  input wire logic [15:0]         adr,
  input wire logic [15:0]         dat,
  // observed bus
  output crcsn_pkg::crcsn_snoop_s bus
);
  logic [15:0] idle_q = 16'h5A3C;

  // idle address and data keep moving so stale values never look valid
  always_ff @(posedge aclk) begin
    idle_q <= {idle_q[14:0], ~idle_q[15]};
  end

  // each access lasts one cycle whatever the crc block does
  always_comb begin
    bus.valid = go;
    bus.write = go ? wr : idle_q[0];
    bus.word  = 1'b1;
    bus.addr  = go ? adr : idle_q;
    bus.data  = go ? dat : ~idle_q;
  end
endmodule  // crcsn_periph_model

// [sim/crcsn_top_tb.sv]
// self-checking bench for the crc snoop block
`timescale 1ns/1ps
module crcsn_top_tb;
  logic        aclk, aresetn, ce, go, wr, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] adr, dat, c;
  int          miscompares, checks;
  crcsn_pkg::crcsn_snoop_s snoop_bus;

  crcsn_top crcsn_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .snoop_bus);
  crcsn_periph_model crcsn_periph_model_i (.aclk, .go, .wr, .adr, .dat, .bus(snoop_bus));

  // msb-first reference fold, no reflection
  function automatic logic [15:0] fold(input logic [15:0] v, input logic [7:0] b, input logic p);
    v = v ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      v = v[15] ? ((v << 1) ^ (p ? 16'h8005 : 16'h1021)) : (v << 1);
    return v;
  endfunction

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = crcsn_pkg::RESP_OKAY);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    chk({32'h0, r}, {32'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = crcsn_pkg::RESP_OKAY);
    logic g, v;
    logic [33:0] d;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      g = s_axi_arready;
      v = s_axi_rvalid;
      d = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (g) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
    chk(d, {er, e});
  endtask

  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge aclk);
    go <= 1'b1;
    wr <= w;
    adr <= a;
    dat <= d;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  task automatic t_sw(input logic p, input logic [15:0] e);
    logic [71:0] m;
    m = "123456789";
    wrc(crcsn_pkg::OFF_CTRL, {31'h0, p});
    wrc(crcsn_pkg::OFF_RESULT, p ? 32'h0 : 32'hFFFF);
    c = p ? 16'h0 : 16'hFFFF;
    for (int i = 0; i < 9; i++) begin
      wrc(crcsn_pkg::OFF_INPUT, {24'h0, m[71-8*i -: 8]});
      c = fold(c, m[71-8*i -: 8], p);
      rdc(crcsn_pkg::OFF_RESULT, {16'h0, c});
    end
    rdc(crcsn_pkg::OFF_INPUT, 32'h39);
    chk({18'h0, c}, {18'h0, e});
  endtask

  task automatic t_snoop();
    wrc(crcsn_pkg::OFF_CTRL, 32'h0);
    wrc(crcsn_pkg::OFF_RESULT, 32'h1D0F);
    wrc(crcsn_pkg::OFF_SNOOP, 32'h8021);
    acc(1'b1, 16'h0021, 16'hAB12);
    acc(1'b0, 16'h0021, 16'h0034);
    acc(1'b1, 16'h0022, 16'h0056);
    c = fold(16'h1D0F, 8'h12, 1'b0);
    rdc(crcsn_pkg::OFF_INPUT, 32'h12);
    rdc(crcsn_pkg::OFF_RESULT, {16'h0, c});
    wrc(crcsn_pkg::OFF_SNOOP, 32'h4021);
    acc(1'b0, 16'h0021, 16'h5678);
    acc(1'b1, 16'h0021, 16'h009A);
    c = fold(c, 8'h78, 1'b0);
    rdc(crcsn_pkg::OFF_RESULT, {16'h0, c});
    wrc(crcsn_pkg::OFF_SNOOP, 32'hC020);
    acc(1'b1, 16'h0020, 16'h00BC);
    acc(1'b0, 16'h0020, 16'h00DE);
    rdc(crcsn_pkg::OFF_RESULT, {16'h0, c});
    rdc(crcsn_pkg::OFF_SNOOP, 32'hC020);
  endtask

  task automatic t_both();
    wrc(crcsn_pkg::OFF_RESULT, 32'hFFFF);
    wrc(crcsn_pkg::OFF_SNOOP, 32'h8021);
    // snoop lands in the cycle in which the software byte waits in its pending slot
    fork
      begin
        repeat (2) @(posedge aclk);
        acc(1'b1, 16'h0021, 16'h00C3);
      end
      wrc(crcsn_pkg::OFF_INPUT, 32'h5A);
    join
    @(posedge aclk);
    c = fold(fold(16'hFFFF, 8'hC3, 1'b0), 8'h5A, 1'b0);
    rdc(crcsn_pkg::OFF_RESULT, {16'h0, c});
  endtask

  task automatic t_burst();
    logic [7:0] b;
    wrc(crcsn_pkg::OFF_RESULT, 32'h0);
    c = 16'h0;
    for (int i = 0; i < 6; i++) begin
      b = 8'(17 * i + 17);
      @(posedge aclk);
      go <= 1'b1;
      wr <= 1'b1;
      dat <= {8'hE7, b};
      c = fold(c, b, 1'b0);
    end
    @(posedge aclk);
    go <= 1'b0;
    rdc(crcsn_pkg::OFF_RESULT, {16'h0, c});
    rdc(crcsn_pkg::OFF_STATUS, 32'h0);
  endtask

  task automatic t_err();
    wrc(8'h14, 32'h1, crcsn_pkg::RESP_SLVERR);
    rdc(8'h14, 32'h0, crcsn_pkg::RESP_SLVERR);
    wrc(crcsn_pkg::OFF_STATUS, 32'h2);
    rdc(crcsn_pkg::OFF_STATUS, 32'h0);
    @(posedge aclk);
    ce <= 1'b0;
    @(negedge aclk);
    chk({33'h0, s_axi_awready}, 34'h0);
    @(posedge aclk);
    ce <= 1'b1;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdc(8'(4 * i), 32'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    {aresetn, go, wr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adr, dat} = '0;
    ce = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdc(8'(4 * i), 32'h0);
    t_sw(1'b0, 16'h29B1);
    t_sw(1'b1, 16'hFEE8);
    t_snoop();
    t_both();
    t_burst();
    t_err();
    complete_run();
  end

  initial begin
    #500us;
    miscompares++;
    complete_run();
  end
endmodule  // crcsn_top_tb
